// >>> core/serial_link_control.v
// Link control and output/conversion control register bank of the serializer
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "serial_link_control_regs.vh"

// Functional notes
// - Link-control bit 7 turns the serial link on or off and its power-up value follows the straps.
// - For 500 us after the serial link starts or stops, the back channel is reported unavailable.
// - Link-control bit 4 selects sleep, with a power-up value from the direction pin and straps.
// - Field 3:2 picks I2C (00) or UART (01) base interface while the select pin is low and the direction pin high, 10/11 disable local control, reset 01.
// - Link-control bit 1 enables back-channel reception and resets to one.
// - Link-control bit 0 enables forward-channel sending and resets to one.
// - Conversion bit 7 clear sends the register address, set sends only the command byte.
// - Swing field 5:4 selects 100/200/300/400 mV and resets to 11.
// - With the configuration lock set, registers 0x00 to 0x1F ignore writes.
module serial_link_control #(
   parameter [31:0] QUIET_CYC = `BACK_QUIET_CYC        // Back-channel quiet time in cycles
) (
   input  wire       sys_clk_i,              // System clock, 40 MHz
   input  wire       rst_i,                  // Asynchronous reset, active high
   input  wire [7:0] addr_i,                 // Register address
   input  wire [7:0] wdata_i,                // Write data
   input  wire       wr_i,                   // Write strobe
   input  wire       rd_i,                   // Read strobe
   output reg  [7:0] rdata_o,                // Read data, cycle after strobe
   input  wire [1:0] config_strap_pins_hi_i, // Configuration straps
   input  wire       ctrl_direction_pin_i,   // Control direction pin
   input  wire       iface_select_pin_i,     // Interface select pin
   output reg        serial_link_on_o,       // Serial link enable
   output reg        config_link_on_o,       // Configuration link enable
   output reg        test_pattern_on_o,      // Test pattern enable
   output reg        sleep_o,                // Sleep mode
   output reg        base_i2c_o,             // Local control uses I2C
   output reg        base_uart_o,            // Local control uses UART
   output reg        local_ctrl_off_o,       // Local control channel disabled
   output reg        back_channel_rx_o,      // Back-channel reception usable
   output reg        fwd_channel_send_on_o,  // Forward channel sending enable
   output reg        addr_byte_omit_o,       // Command-byte-only conversion
   output reg        jitter_filter_off_o,    // Jitter filter disable
   output reg  [1:0] output_swing_level_o,   // Output swing code
   output reg  [3:0] emphasis_setting_o,     // Emphasis code
   output reg        back_channel_busy_o     // Back channel in quiet time
);

   reg  [1:0]  strap_s1_r;
   reg  [1:0]  strap_s2_r;
   reg         dir_s1_r;
   reg         dir_s2_r;
   reg         sel_s1_r;
   reg         sel_s2_r;
   reg  [1:0]  sync_cnt_r;
   reg  [7:0]  link_control_r;
   reg  [7:0]  output_conv_r;
   reg  [7:0]  lock_r;
   reg         serial_prev_r;
   reg  [31:0] quiet_cnt_r;
   reg  [31:0] quiet_cnt_nxt;
   wire        locked;
   wire        wr_ok;
   wire        straps_ready;
   wire        strap_serial;
   wire        strap_sleep;
   wire        emph_forbid;
   wire [1:0]  iface;
   reg  [7:0]  rdata_nxt;

   assign locked       = lock_r[`LOCK_BIT];
   assign wr_ok        = wr_i & ~locked;
   assign straps_ready = (sync_cnt_r == 2'd2);
   // Strap decode: link on when either high strap set; sleep only when local side is host-less
   assign strap_serial = |strap_s2_r;
   assign strap_sleep  = ~dir_s2_r & ~(|strap_s2_r);
   assign emph_forbid  = (wdata_i[`OC_EMPH_HI:`OC_EMPH_LO] >= `EMPH_FORBID_LO) &&
                         (wdata_i[`OC_EMPH_HI:`OC_EMPH_LO] <= `EMPH_FORBID_HI);
   assign iface        = link_control_r[`LC_IFACE_HI:`LC_IFACE_LO];

   // Pin synchronisers and strap capture delay after reset release
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_s1_r <= 2'b00;
         strap_s2_r <= 2'b00;
         dir_s1_r   <= 1'b0;
         dir_s2_r   <= 1'b0;
         sel_s1_r   <= 1'b0;
         sel_s2_r   <= 1'b0;
         sync_cnt_r <= 2'd0;
      end else begin
         strap_s1_r <= config_strap_pins_hi_i;
         strap_s2_r <= strap_s1_r;
         dir_s1_r   <= ctrl_direction_pin_i;
         dir_s2_r   <= dir_s1_r;
         sel_s1_r   <= iface_select_pin_i;
         sel_s2_r   <= sel_s1_r;
         if (sync_cnt_r != 2'd3) begin
            sync_cnt_r <= sync_cnt_r + 2'd1;
         end
      end
   end

   // Register file
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         link_control_r <= `LC_RESET_FIXED;
         output_conv_r  <= `OC_RESET;
         lock_r         <= `LOCK_RESET;
      end else begin
         if (straps_ready) begin
            link_control_r[`LC_SERIAL_ON] <= strap_serial;
            link_control_r[`LC_SLEEP]     <= strap_sleep;
         end
         if (wr_ok && addr_i == `ADDR_LINK_CONTROL) begin
            link_control_r <= wdata_i;
         end
         if (wr_ok && addr_i == `ADDR_OUTPUT_CONV) begin
            output_conv_r[`OC_ADDR_OMIT:`OC_SWING_LO] <= wdata_i[7:4];
            if (!emph_forbid) begin
               output_conv_r[`OC_EMPH_HI:`OC_EMPH_LO] <=
                  wdata_i[`OC_EMPH_HI:`OC_EMPH_LO];
            end
         end
         if (wr_ok && addr_i == `ADDR_LOCK) begin
            lock_r[`LOCK_BIT] <= wdata_i[`LOCK_BIT];
         end
      end
   end

   // Quiet-time counter restarts on every change of the serial link enable
   always @* begin
      quiet_cnt_nxt = quiet_cnt_r;
      if (serial_prev_r != link_control_r[`LC_SERIAL_ON]) begin
         quiet_cnt_nxt = QUIET_CYC;
      end else if (quiet_cnt_r != 32'h0000_0000) begin
         quiet_cnt_nxt = quiet_cnt_r - 32'h0000_0001;
      end
   end

   always @* begin
      rdata_nxt = 8'h00;
      case (addr_i)
         `ADDR_LOCK:         rdata_nxt = lock_r;
         `ADDR_LINK_CONTROL: rdata_nxt = link_control_r;
         `ADDR_OUTPUT_CONV:  rdata_nxt = output_conv_r;
         default:            rdata_nxt = 8'h00;
      endcase
   end

   // Outputs
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_prev_r         <= 1'b0;
         quiet_cnt_r           <= 32'h0000_0000;
         rdata_o               <= 8'h00;
         serial_link_on_o      <= 1'b0;
         config_link_on_o      <= 1'b0;
         test_pattern_on_o     <= 1'b0;
         sleep_o               <= 1'b0;
         base_i2c_o            <= 1'b0;
         base_uart_o           <= 1'b0;
         local_ctrl_off_o      <= 1'b0;
         back_channel_rx_o     <= 1'b0;
         fwd_channel_send_on_o <= 1'b0;
         addr_byte_omit_o      <= 1'b0;
         jitter_filter_off_o   <= 1'b1;
         output_swing_level_o  <= 2'b11;
         emphasis_setting_o    <= 4'h0;
         back_channel_busy_o   <= 1'b0;
      end else begin
         serial_prev_r         <= link_control_r[`LC_SERIAL_ON];
         quiet_cnt_r           <= quiet_cnt_nxt;
         rdata_o               <= rd_i ? rdata_nxt : 8'h00;
         serial_link_on_o      <= link_control_r[`LC_SERIAL_ON];
         config_link_on_o      <= link_control_r[`LC_CONFIG_LINK];
         test_pattern_on_o     <= link_control_r[`LC_TEST_PATTERN];
         sleep_o               <= link_control_r[`LC_SLEEP];
         base_i2c_o            <= (iface == `IFACE_I2C) & ~sel_s2_r & dir_s2_r;
         base_uart_o           <= (iface == `IFACE_UART) & ~sel_s2_r & dir_s2_r;
         local_ctrl_off_o      <= iface[1];
         back_channel_rx_o     <= link_control_r[`LC_BACK_RX] &
                                  (quiet_cnt_nxt == 32'h0000_0000);
         fwd_channel_send_on_o <= link_control_r[`LC_FWD_TX];
         addr_byte_omit_o      <= output_conv_r[`OC_ADDR_OMIT];
         jitter_filter_off_o   <= output_conv_r[`OC_JITTER_OFF];
         output_swing_level_o  <= output_conv_r[`OC_SWING_HI:`OC_SWING_LO];
         emphasis_setting_o    <= output_conv_r[`OC_EMPH_HI:`OC_EMPH_LO];
         back_channel_busy_o   <= (quiet_cnt_nxt != 32'h0000_0000);
      end
   end

endmodule

// >>> core/serial_link_control_regs.vh
// Register offsets, field positions, reset values and timing counts of the link control bank
`ifndef SERIAL_LINK_CONTROL_REGS_VH
`define SERIAL_LINK_CONTROL_REGS_VH

`define ADDR_LOCK          8'h00
`define ADDR_LINK_CONTROL  8'h04
`define ADDR_OUTPUT_CONV   8'h05

`define LOCK_BIT           0

`define LC_SERIAL_ON       7
`define LC_CONFIG_LINK     6
`define LC_TEST_PATTERN    5
`define LC_SLEEP           4
`define LC_IFACE_HI        3
`define LC_IFACE_LO        2
`define LC_BACK_RX         1
`define LC_FWD_TX          0

`define OC_ADDR_OMIT       7
`define OC_JITTER_OFF      6
`define OC_SWING_HI        5
`define OC_SWING_LO        4
`define OC_EMPH_HI         3
`define OC_EMPH_LO         0

`define LC_RESET_FIXED     8'h07
`define OC_RESET           8'h70
`define LOCK_RESET         8'h00

`define IFACE_I2C          2'b00
`define IFACE_UART         2'b01

`define EMPH_FORBID_LO     4'h5
`define EMPH_FORBID_HI     4'h7

`define CLK_MHZ            40
`define BACK_QUIET_US      500
`define BACK_QUIET_CYC     (`BACK_QUIET_US * `CLK_MHZ)

`endif

// >>> sim/serial_link_control_chk.sv
// Port assertions for the link control register bank
`timescale 1ns/1ps
`include "serial_link_control_regs.vh"
module serial_link_control_chk (
   input wire sys_clk_i,             // Clock
   input wire rst_i,                 // Reset
   input wire [7:0] addr_i,          // Address
   input wire rd_i,                  // Read
   input wire [7:0] rdata_o,         // Data
   input wire serial_link_on_o,      // Link
   input wire sleep_o,               // Sleep
   input wire local_ctrl_off_o,      // Local off
   input wire back_channel_rx_o,     // Back rx
   input wire back_channel_busy_o,   // Quiet
   input wire fwd_channel_send_on_o, // Fwd
   input wire [1:0] output_swing_level_o, // Swing
   input wire [3:0] emphasis_setting_o    // Emphasis
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   wire rd4 = rd_i && addr_i == `ADDR_LINK_CONTROL;
   wire rd5 = rd_i && addr_i == `ADDR_OUTPUT_CONV;
   AST_SERIAL: assert property ($past(rd4) |-> rdata_o[7] == serial_link_on_o)
      else $error("link enable");
   AST_QUIET: assert property ($changed(serial_link_on_o) |-> back_channel_busy_o && !back_channel_rx_o)
      else $error("quiet start");
   AST_SLEEP: assert property ($past(rd4) |-> rdata_o[4] == sleep_o)
      else $error("sleep");
   AST_IFACE: assert property ($past(rd4) |-> local_ctrl_off_o == rdata_o[3])
      else $error("local off");
   AST_BACK_RX: assert property ($past(rd4) |-> back_channel_rx_o == (rdata_o[1] && !back_channel_busy_o))
      else $error("back rx");
   AST_FWD: assert property ($past(rd4) |-> fwd_channel_send_on_o == rdata_o[0])
      else $error("fwd send");
   AST_SWING: assert property ($past(rd5) |-> output_swing_level_o == rdata_o[5:4])
      else $error("swing");
   AST_EMPH: assert property ($changed(emphasis_setting_o) |-> !(emphasis_setting_o inside {[4'h5:4'h7]}))
      else $error("emphasis");
endmodule
bind serial_link_control serial_link_control_chk chk (.*);

// >>> sim/mcu_bus_model.sv
// Microcontroller model that programs the bank over the register port
`timescale 1ns/1ps
module mcu_bus_model (
   input wire clk_i,                 // Clock
   output reg [7:0] addr_o = 8'h00,  // Address
   output reg [7:0] wdata_o = 8'h00, // Write data
   output reg wr_o = 1'b0,           // Write
   output reg rd_o = 1'b0,           // Read
   input wire [7:0] rdata_i          // Read data
);
   task wr(input [7:0] a, input [7:0] d);
      begin
         {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
         @(posedge clk_i) {wr_o, addr_o, wdata_o} <= {1'b0, ~a, ~d};
         #1;
      end
   endtask
   task rd(input [7:0] a, output [7:0] d);
      begin
         {rd_o, addr_o} <= {1'b1, a};
         @(posedge clk_i) {rd_o, addr_o} <= {1'b0, ~a};
         #1 d = rdata_i;
      end
   endtask
endmodule

// >>> sim/serial_link_control_tb.sv
// Self-checking bench of the link control register bank
`timescale 1ns/1ps
`include "serial_link_control_regs.vh"
module serial_link_control_tb;
   localparam QC = 20;
   reg sys_clk_i = 1'b0, rst_i = 1'b1, ctrl_direction_pin_i = 1'b1, iface_select_pin_i = 1'b0;
   reg [1:0] config_strap_pins_hi_i = 2'b00;
   reg [7:0] g, lc, oc;
   wire [7:0] addr_i, wdata_i, rdata_o;
   wire [3:0] emphasis_setting_o;
   wire [1:0] output_swing_level_o;
   wire wr_i, rd_i, serial_link_on_o, config_link_on_o, test_pattern_on_o, sleep_o, base_i2c_o,
      base_uart_o, local_ctrl_off_o, back_channel_rx_o, fwd_channel_send_on_o, addr_byte_omit_o,
      jitter_filter_off_o, back_channel_busy_o;
   integer seed = 32'hffce_5deb, miscompares = 0, n_tests = 0, i, r;
   always #12.5 sys_clk_i = ~sys_clk_i;
   serial_link_control #(.QUIET_CYC(QC)) uut (.*);
   mcu_bus_model mcu (.clk_i(sys_clk_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
      .rd_o(rd_i), .rdata_i(rdata_o));
   function [7:0] nxt_oc(input [7:0] old, input [7:0] w);
      nxt_oc = (w[3:0] >= 4'h5 && w[3:0] <= 4'h7) ? {w[7:4], old[3:0]} : w;
   endfunction
   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task tally_and_finish;
      begin
         if (miscompares == 0 && n_tests > 0) $display("Regression OK");
         else $display("Regression broken");
         $finish;
      end
   endtask
   task do_reset;
      begin
         r = $random(seed);
         {rst_i, ctrl_direction_pin_i, config_strap_pins_hi_i} <= {1'b1, r[2:0]};
         repeat (5) @(posedge sys_clk_i);
         rst_i <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
         lc = {|r[1:0], 2'b00, ~r[2] & ~|r[1:0], 4'h7};
         oc = `OC_RESET;
      end
   endtask
   initial begin
      do_reset;
      mcu.rd(`ADDR_LINK_CONTROL, g); chk(g, lc);
      mcu.rd(`ADDR_OUTPUT_CONV, g); chk(g, oc);
      mcu.rd(8'h06, g); chk(g, 8'h00);
      for (i = 0; i < 12; i = i + 1) begin
         r = $random(seed);
         if (i == 0) r[3:0] = 4'h6;
         mcu.wr(`ADDR_OUTPUT_CONV, r[7:0]);
         oc = nxt_oc(oc, r[7:0]);
         mcu.rd(`ADDR_OUTPUT_CONV, g); chk(g, oc);
         chk({addr_byte_omit_o, jitter_filter_off_o, output_swing_level_o, emphasis_setting_o}, oc);
      end
      for (i = 0; i < 6; i = i + 1) begin
         r = $random(seed);
         if (i < 4) begin
            r[9:8] = 2'b01;
            r[3:2] = i[1:0];
         end
         {iface_select_pin_i, ctrl_direction_pin_i} <= r[9:8];
         r[7] = ~lc[7];
         mcu.wr(`ADDR_LINK_CONTROL, r[7:0]);
         lc = r[7:0];
         @(posedge sys_clk_i) #1 chk({6'h00, back_channel_busy_o, back_channel_rx_o}, 8'h02);
         repeat (QC + 2) @(posedge sys_clk_i);
         mcu.rd(`ADDR_LINK_CONTROL, g); chk(g, lc);
         chk({serial_link_on_o, config_link_on_o, test_pattern_on_o, sleep_o, local_ctrl_off_o,
            base_uart_o, back_channel_rx_o, fwd_channel_send_on_o}, {lc[7:3], lc[3:2] == 2'b01
            && r[9:8] == 2'b01, lc[1:0]});
         chk({7'h00, base_i2c_o}, {7'h00, lc[3:2] == 2'b00 && r[9:8] == 2'b01});
      end
      mcu.wr(`ADDR_LOCK, 8'h01);
      mcu.wr(`ADDR_LINK_CONTROL, ~lc);
      mcu.wr(`ADDR_OUTPUT_CONV, ~oc);
      mcu.wr(`ADDR_LOCK, 8'h00);
      mcu.rd(`ADDR_LINK_CONTROL, g); chk(g, lc);
      mcu.rd(`ADDR_OUTPUT_CONV, g); chk(g, oc);
      mcu.rd(`ADDR_LOCK, g); chk(g, 8'h01);
      do_reset;
      mcu.rd(`ADDR_LOCK, g); chk(g, 8'h00);
      mcu.rd(`ADDR_LINK_CONTROL, g); chk(g, lc);
      tally_and_finish;
   end
   initial begin
      #(25 * 3000);
      miscompares = miscompares + 1;
      tally_and_finish;
   end
endmodule
